/* File: logic/rcb_top.sv */
/*
 rcb_top: cascade bus port of a multiport repeater, with its transmit FIFO.
 Assumes i_clock at 125 MHz and a bit clock from other chips on its own domain;
 bus wires are resolved outside from the _oe_b enables (low = driving).
*/
// Operation
// - as bus source the block sends repeated data as a serial NRZ bit stream.
// - data, frame, clock and collision are driven only while an own segment receives.
// - by default those four lines are inputs so another chip may drive them.
// - as source the frame enable marks the span of the serial activity.
// - as source a bit clock goes out and data changes on each falling edge.
// - with the bit clock as input, data is sampled on its rising edge, held stable there.
// - the collision line shows a collision on the port being repeated.
// - the buffer enable is high while the block drives the four lines.
// - the buffer enable is low whenever the block is not source.
// - all transmit timing derives from one reference clock of the stated rate; receive runs on the incoming bit clock.
// - the activity drive is active while any own segment brings data or collision.
// - the activity sense shows that this or any cascaded chip is receiving.
// - the multi-collision drive is active on a transmit collision or several port collisions.
// - the multi-collision sense shows such collisions anywhere in the cascade.
// - an acknowledge enters the arbitration chain and one is passed onward.
`timescale 1ns/1ps
`default_nettype none

module rcb_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
      logic room;
   } rcb_fifo_type;
   rcb_fifo_type cur_ff, nxt_cur;
   logic do_wr, do_rd;

   // ready kept in a flop so the top's port is registered; valid from the count
   assign o_ready = cur_ff.room;
   assign o_valid = (cur_ff.count != '0);
   assign o_data = cur_ff.mem[cur_ff.rd];
   assign do_wr = i_valid & o_ready;
   assign do_rd = i_ready & o_valid;

   // pointers wrap, depth is a power of two
   always_comb begin
      nxt_cur = cur_ff;
      if (do_wr) begin
         nxt_cur.mem[cur_ff.wr] = i_data;
         nxt_cur.wr = cur_ff.wr + 1'b1;
      end
      if (do_rd) begin
         nxt_cur.rd = cur_ff.rd + 1'b1;
      end
      if (do_wr && !do_rd) begin
         nxt_cur.count = cur_ff.count + 1'b1;
      end else if (do_rd && !do_wr) begin
         nxt_cur.count = cur_ff.count - 1'b1;
      end
      // room left after this edge, same timing as a decode of the stored count
      nxt_cur.room = (nxt_cur.count != (AW+1)'(DEPTH));
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cur_ff <= '0;
         cur_ff.room <= 1'b1;
      end else begin
         cur_ff <= nxt_cur;
      end
   end
endmodule

module rcb_top #(
   parameter int unsigned NPORTS = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   // own port status from the port logic, same clock
   input wire logic [NPORTS-1:0] i_port_rx,
   input wire logic [NPORTS-1:0] i_port_collision,
   input wire logic i_tx_collision,
   // bytes to repeat, LSB sent first
   input wire logic i_tx_valid,
   input wire logic [rcb_pkg::BYTE_W-1:0] i_tx_data,
   output logic o_tx_ready,
   // bytes heard from another chip
   output logic o_rx_valid,
   output logic [rcb_pkg::BYTE_W-1:0] o_rx_data,
   output logic o_rx_end,
   output logic o_rx_collision,
   // arbitration chain
   input wire logic i_arb_chain_in,
   output logic o_arb_chain_out,
   // shared cascade lines
   input wire logic i_cascade_data,
   output logic o_cascade_data,
   output logic o_cascade_data_oe_b,
   input wire logic i_cascade_frame,
   output logic o_cascade_frame,
   output logic o_cascade_frame_oe_b,
   input wire logic i_cascade_bit_clock,
   output logic o_cascade_bit_clock,
   output logic o_cascade_bit_clock_oe_b,
   input wire logic i_cascade_collision,
   output logic o_cascade_collision,
   output logic o_cascade_collision_oe_b,
   output logic o_cascade_buffer_enable,
   // open-drain wired-OR lines and their senses
   output logic o_activity_drive,
   output logic o_activity_drive_oe_b,
   input wire logic i_activity_sense,
   output logic o_bus_active,
   output logic o_multi_collision_drive,
   output logic o_multi_collision_drive_oe_b,
   input wire logic i_multi_collision_sense,
   output logic o_multi_collision
);
   localparam logic [rcb_pkg::DIV_W-1:0] HALF_LAST =
      rcb_pkg::DIV_W'(rcb_pkg::BIT_HALF_CYC - 1);

   typedef struct packed {
      logic arb_s1, arb_s2, act_s1, act_s2, mcol_s1, mcol_s2;
      logic frm_s1, frm_s2, frm_s3, col_s1, col_s2;
      logic tog_s1, tog_s2, tog_s3;
      logic source, arb_out, act_oe_b, mcol_oe_b, pin_oe_b, buf_en;
      logic frame_o, clk_o, data_o, coll_o, pop;
      logic [rcb_pkg::DIV_W-1:0] div;
      logic [rcb_pkg::BYTE_W-1:0] shift;
      logic [2:0] bits;
      logic loaded;
      logic bus_active, multi_col, rx_valid, rx_end, rx_col;
      logic [rcb_pkg::BYTE_W-1:0] rx_data;
   } rcb_sys_type;

   typedef struct packed {
      logic [rcb_pkg::BYTE_W-1:0] shift;
      logic [2:0] cnt;
      logic [rcb_pkg::BYTE_W-1:0] hold;
      logic tog;
   } rcb_link_type;

   rcb_sys_type sys_ff, nxt_sys;
   rcb_link_type link_ff, nxt_link;
   logic fifo_valid;
   logic [rcb_pkg::BYTE_W-1:0] fifo_data;
   logic claim;

   // more than one bit set, used for the multi-collision test
   function automatic logic many(input logic [NPORTS-1:0] v);
      many = ((v & (v - 1'b1)) != '0);
   endfunction

   // transmit bytes wait here; the serializer drains one per byte time
   rcb_fifo #(
      .WIDTH(rcb_pkg::BYTE_W),
      .DEPTH(rcb_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_valid(i_tx_valid),
      .i_data(i_tx_data),
      .o_ready(o_tx_ready),
      .o_valid(fifo_valid),
      .o_data(fifo_data),
      .i_ready(sys_ff.pop)
   );

   assign claim = |i_port_rx;

   // system domain: arbitration, pin drive, serializer, receive handoff
   always_comb begin
      nxt_sys = sys_ff;
      // two-flop synchronisers for pins from other chips
      nxt_sys.arb_s1 = i_arb_chain_in;
      nxt_sys.arb_s2 = sys_ff.arb_s1;
      nxt_sys.act_s1 = i_activity_sense;
      nxt_sys.act_s2 = sys_ff.act_s1;
      nxt_sys.mcol_s1 = i_multi_collision_sense;
      nxt_sys.mcol_s2 = sys_ff.mcol_s1;
      nxt_sys.frm_s1 = i_cascade_frame;
      nxt_sys.frm_s2 = sys_ff.frm_s1;
      nxt_sys.frm_s3 = sys_ff.frm_s2;
      nxt_sys.col_s1 = i_cascade_collision;
      nxt_sys.col_s2 = sys_ff.col_s1;
      nxt_sys.tog_s1 = link_ff.tog;
      nxt_sys.tog_s2 = sys_ff.tog_s1;
      nxt_sys.tog_s3 = sys_ff.tog_s2;
      // first claimer holding the acknowledge wins the bus
      nxt_sys.arb_out = sys_ff.arb_s2 & ~claim;
      nxt_sys.source = claim & sys_ff.arb_s2;
      nxt_sys.pin_oe_b = ~nxt_sys.source;
      nxt_sys.buf_en = nxt_sys.source;
      nxt_sys.frame_o = nxt_sys.source;
      nxt_sys.coll_o = nxt_sys.source & (|i_port_collision);
      // open-drain: enable low pulls the shared line low
      nxt_sys.act_oe_b = ~(claim | (|i_port_collision));
      nxt_sys.mcol_oe_b = ~(i_tx_collision | many(i_port_collision));
      // wired-OR lines are low when any chip is active
      nxt_sys.bus_active = ~sys_ff.act_s2;
      nxt_sys.multi_col = ~sys_ff.mcol_s2;
      nxt_sys.pop = 1'b0;
      if (!nxt_sys.source) begin
         // idle: no bit clock, serializer emptied; a byte in flight is dropped
         nxt_sys.div = '0;
         nxt_sys.clk_o = 1'b0;
         nxt_sys.data_o = 1'b0;
         nxt_sys.bits = '0;
         nxt_sys.loaded = 1'b0;
      end else if (sys_ff.div == HALF_LAST) begin
         // bit clock derived from the one system clock
         nxt_sys.div = '0;
         nxt_sys.clk_o = ~sys_ff.clk_o;
         if (sys_ff.clk_o) begin
            // falling edge: next NRZ bit goes out
            if (sys_ff.loaded) begin
               nxt_sys.data_o = sys_ff.shift[0];
               nxt_sys.shift = {1'b0, sys_ff.shift[rcb_pkg::BYTE_W-1:1]};
               nxt_sys.bits = sys_ff.bits - 1'b1;
               nxt_sys.loaded = (sys_ff.bits != 3'h1);
            end else if (fifo_valid) begin
               nxt_sys.data_o = fifo_data[0];
               nxt_sys.shift = {1'b0, fifo_data[rcb_pkg::BYTE_W-1:1]};
               nxt_sys.bits = rcb_pkg::LAST_BIT;
               nxt_sys.loaded = 1'b1;
               nxt_sys.pop = 1'b1;
            end else begin
               // underrun fills with zeros rather than stopping the clock
               nxt_sys.data_o = 1'b0;
            end
         end
      end else begin
         nxt_sys.div = sys_ff.div + 1'b1;
      end
      // receive handoff: toggle seen after two flops, hold byte is stable by then
      nxt_sys.rx_valid = (sys_ff.tog_s3 ^ sys_ff.tog_s2) & ~sys_ff.source;
      if (nxt_sys.rx_valid) begin
         nxt_sys.rx_data = link_ff.hold;
      end
      nxt_sys.rx_end = sys_ff.frm_s3 & ~sys_ff.frm_s2 & ~sys_ff.source;
      nxt_sys.rx_col = sys_ff.col_s2 & ~sys_ff.source;
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sys_ff <= '0;
         sys_ff.pin_oe_b <= rcb_pkg::OE_RELEASED;
         sys_ff.act_oe_b <= rcb_pkg::OE_RELEASED;
         sys_ff.mcol_oe_b <= rcb_pkg::OE_RELEASED;
         sys_ff.act_s1 <= 1'b1;
         sys_ff.act_s2 <= 1'b1;
         sys_ff.mcol_s1 <= 1'b1;
         sys_ff.mcol_s2 <= 1'b1;
      end else begin
         sys_ff <= nxt_sys;
      end
   end

   // link domain: shift in on the rising edge of the incoming bit clock
   always_comb begin
      nxt_link = link_ff;
      if (i_cascade_frame) begin
         nxt_link.shift = {i_cascade_data, link_ff.shift[rcb_pkg::BYTE_W-1:1]};
         nxt_link.cnt = link_ff.cnt + 1'b1;
         if (link_ff.cnt == rcb_pkg::LAST_BIT) begin
            nxt_link.hold = nxt_link.shift;
            nxt_link.tog = ~link_ff.tog;
         end
      end else begin
         // a partial byte at frame end is discarded
         nxt_link.cnt = '0;
      end
   end

   always_ff @(posedge i_cascade_bit_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         link_ff <= '0;
      end else begin
         link_ff <= nxt_link;
      end
   end

   // every output straight from a flop, except the two open-drain drive levels tied low
   assign o_arb_chain_out = sys_ff.arb_out;
   assign o_cascade_data = sys_ff.data_o;
   assign o_cascade_data_oe_b = sys_ff.pin_oe_b;
   assign o_cascade_frame = sys_ff.frame_o;
   assign o_cascade_frame_oe_b = sys_ff.pin_oe_b;
   assign o_cascade_bit_clock = sys_ff.clk_o;
   assign o_cascade_bit_clock_oe_b = sys_ff.pin_oe_b;
   assign o_cascade_collision = sys_ff.coll_o;
   assign o_cascade_collision_oe_b = sys_ff.pin_oe_b;
   assign o_cascade_buffer_enable = sys_ff.buf_en;
   assign o_activity_drive = 1'b0;
   assign o_activity_drive_oe_b = sys_ff.act_oe_b;
   assign o_multi_collision_drive = 1'b0;
   assign o_multi_collision_drive_oe_b = sys_ff.mcol_oe_b;
   assign o_bus_active = sys_ff.bus_active;
   assign o_multi_collision = sys_ff.multi_col;
   assign o_rx_valid = sys_ff.rx_valid;
   assign o_rx_data = sys_ff.rx_data;
   assign o_rx_end = sys_ff.rx_end;
   assign o_rx_collision = sys_ff.rx_col;

   // checks on the system domain, and one on the incoming bit clock
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   a_buf_en_drive: assert property (
      o_cascade_buffer_enable |-> !o_cascade_data_oe_b && !o_cascade_frame_oe_b
         && !o_cascade_bit_clock_oe_b && !o_cascade_collision_oe_b)
      else $error("buffer enable high while lines not driven");
   a_idle_inputs: assert property (
      !o_cascade_buffer_enable |-> o_cascade_data_oe_b && o_cascade_bit_clock_oe_b
         && o_cascade_frame_oe_b && o_cascade_collision_oe_b)
      else $error("lines driven while not source");
   a_source_cause: assert property (
      $rose(o_cascade_buffer_enable) |-> $past(claim) && $past(sys_ff.arb_s2))
      else $error("became source without claim and acknowledge");
   a_frame_span: assert property (
      o_cascade_frame == o_cascade_buffer_enable)
      else $error("frame does not match source span");
   a_data_on_fall: assert property (
      o_cascade_buffer_enable && $past(o_cascade_buffer_enable) && $changed(o_cascade_data)
         |-> $fell(o_cascade_bit_clock))
      else $error("data changed away from falling clock edge");
   a_clock_half: assert property (
      o_cascade_buffer_enable && $fell(o_cascade_bit_clock)
         |-> $past(o_cascade_bit_clock, 7) && $past(o_cascade_bit_clock, 4))
      else $error("bit clock high phase too short");
   a_coll_repeat: assert property (
      o_cascade_buffer_enable && $past(|i_port_collision) |-> o_cascade_collision)
      else $error("collision on repeated port not shown");
   a_act_drive: assert property (
      (|i_port_rx) |=> !o_activity_drive_oe_b)
      else $error("activity drive not pulled");
   a_multi_drive: assert property (
      i_tx_collision || many(i_port_collision) |=> !o_multi_collision_drive_oe_b)
      else $error("multi-collision drive not pulled");
   a_act_sense: assert property (
      $past(i_activity_sense, 3) == 1'b0 |-> o_bus_active)
      else $error("activity sense not reported");
   a_multi_sense: assert property (
      $past(i_multi_collision_sense, 3) == 1'b0 |-> o_multi_collision)
      else $error("multi-collision sense not reported");
   a_chain_pass: assert property (
      o_arb_chain_out |-> !$past(claim) && $past(sys_ff.arb_s2))
      else $error("acknowledge passed while claiming");
   a_rx_sample: assert property (
      @(posedge i_cascade_bit_clock) disable iff (!i_rst_b)
      i_cascade_frame |=> link_ff.shift[7] == $past(i_cascade_data))
      else $error("bit not sampled on rising edge");

   c_source_coll: cover property (o_cascade_buffer_enable && o_cascade_collision);
   c_rx_byte: cover property (o_rx_valid ##[1:300] o_rx_end);
   c_fifo_full: cover property (!o_tx_ready && o_cascade_buffer_enable);
   c_multi_col: cover property (!o_multi_collision_drive_oe_b && o_multi_collision);
endmodule
`default_nettype wire

/* File: logic/rcb_pkg.sv */
/*
 rcb_pkg: constants shared by the cascade bus port.
 Assumes transmit runs from one 125 MHz system clock, receive from the incoming bit clock.
*/
`default_nettype none
package rcb_pkg;
   // system clock, the one timing reference of the transmit side
   localparam int unsigned CLK_PERIOD_NS = 8;
   // half period of the outgoing bit clock, least figure
   localparam int unsigned BIT_HALF_NS = 50;
   localparam int unsigned BIT_HALF_CYC = (BIT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_W = 4;
   // word width and depth of the transmit buffer
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   // bits in a byte less one, for the bit counters
   localparam logic [2:0] LAST_BIT = 3'h7;
   // reset level of an open-drain enable: released
   localparam logic OE_RELEASED = 1'b1;
endpackage
`default_nettype wire

/* File: verification/rcb_peer.sv */
/*
 rcb_peer: another cascaded chip that sends frames on the shared lines.
 Assumes the bench resolves the wires; frame and collision have pull-downs.
*/
`timescale 1ns/1ps
`default_nettype none
module rcb_peer (
   output logic o_bit_clock,
   output logic o_data,
   output logic o_frame,
   output logic o_collision,
   output logic o_activity_pull,
   output logic o_multi_pull
);
   // idle: bit clock stands still, lines released
   initial begin
      o_bit_clock = 1'b0;
      o_data = 1'b0;
      o_frame = 1'b0;
      o_collision = 1'b0;
      o_activity_pull = 1'b0;
      o_multi_pull = 1'b0;
   end
   // frame of nbits, lsb first, 15 ns bit clock; used only while dut listens
   task automatic send(input int nbits, input logic [63:0] bits, input logic coll);
      o_frame = 1'b1;
      o_collision = coll;
      o_activity_pull = 1'b1;
      o_multi_pull = coll;
      for (int i = 0; i < nbits; i++) begin
         o_data = bits[i]; // moves with clock low, stable at the rise
         #7.5 o_bit_clock = 1'b1;
         #7.5 o_bit_clock = 1'b0;
      end
      o_frame = 1'b0;
      o_collision = 1'b0;
      o_activity_pull = 1'b0;
      o_multi_pull = 1'b0;
      o_data = ~o_data; // released: a stale level must not pass for data
   endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
/*
 testbench: rcb_top with four ports against one peer chip on the cascade lines.
 Assumes the shared wires are resolved here from the oe_b enables.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b1;
   logic [3:0] rx = 4'h0, coll = 4'h0;
   logic txc = 1'b0, ack = 1'b0, tv = 1'b0;
   logic [7:0] td = 8'h00, rx_data;
   logic tr, rv, re, rc, arb_out, d_o, d_oe, f_o, f_oe, k_o, k_oe, c_o, c_oe, buf_en;
   logic a_o, a_oe, bus_act, m_o, m_oe, multi, p_k, p_d, p_f, p_c, p_a, p_m, pd, pk;
   logic w_d, w_f, w_k, w_c, w_a, w_m;
   int errors = 0, checks = 0, ends = 0;
   logic [7:0] got[$], sent[$];
   // rows: {rx, collisions, tx collision, ack, buf_en/arb/activity/multi/collision}
   logic [14:0] rows [9] = '{{4'h0, 4'h0, 2'h1, 5'h08}, {4'h1, 4'h0, 2'h1, 5'h14},
      {4'h1, 4'h0, 2'h0, 5'h04}, {4'h4, 4'h4, 2'h1, 5'h15}, {4'h0, 4'h2, 2'h1, 5'h0C},
      {4'h0, 4'h6, 2'h0, 5'h06}, {4'h0, 4'h0, 2'h3, 5'h0A}, {4'h8, 4'h9, 2'h1, 5'h17},
      {4'hF, 4'h0, 2'h3, 5'h16}};
   // wire levels: oe_b high means released; open-drain lines idle high
   assign w_d = d_oe ? p_d : d_o;
   assign w_f = f_oe ? p_f : f_o;
   assign w_k = k_oe ? p_k : k_o;
   assign w_c = c_oe ? p_c : c_o;
   assign w_a = ~(~a_oe | p_a);
   assign w_m = ~(~m_oe | p_m);
   always #4 i_clock = ~i_clock;
   rcb_peer u_peer (.o_bit_clock(p_k), .o_data(p_d), .o_frame(p_f), .o_collision(p_c),
      .o_activity_pull(p_a), .o_multi_pull(p_m));
   rcb_top #(.NPORTS(4)) u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_port_rx(rx),
      .i_port_collision(coll), .i_tx_collision(txc), .i_tx_valid(tv), .i_tx_data(td),
      .o_tx_ready(tr), .o_rx_valid(rv), .o_rx_data(rx_data), .o_rx_end(re),
      .o_rx_collision(rc), .i_arb_chain_in(ack), .o_arb_chain_out(arb_out),
      .i_cascade_data(w_d), .o_cascade_data(d_o), .o_cascade_data_oe_b(d_oe),
      .i_cascade_frame(w_f), .o_cascade_frame(f_o), .o_cascade_frame_oe_b(f_oe),
      .i_cascade_bit_clock(w_k), .o_cascade_bit_clock(k_o), .o_cascade_bit_clock_oe_b(k_oe),
      .i_cascade_collision(w_c), .o_cascade_collision(c_o), .o_cascade_collision_oe_b(c_oe),
      .o_cascade_buffer_enable(buf_en), .o_activity_drive(a_o), .o_activity_drive_oe_b(a_oe),
      .i_activity_sense(w_a), .o_bus_active(bus_act), .o_multi_collision_drive(m_o),
      .o_multi_collision_drive_oe_b(m_oe), .i_multi_collision_sense(w_m),
      .o_multi_collision(multi));
   task automatic cmp_bit(input logic g, input logic e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: bit %b, expected %b", $time, g, e);
      end
   endtask
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: byte %h, expected %h", $time, g, e);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // data may only move in the cycle the outgoing bit clock falls
   always @(posedge i_clock) begin
      #1;
      if (d_oe === 1'b0 && d_o !== pd) cmp_bit(pk & ~k_o, 1'b1);
      pd = d_o;
      pk = k_o;
   end
   // bytes and frame ends heard from the peer
   always @(posedge i_clock) begin
      #1;
      if (rv === 1'b1) got.push_back(rx_data);
      if (re === 1'b1) ends++;
   end
   // generous bound: the whole run needs about 17 us
   initial begin
      #100000;
      errors++;
      final_report();
   end
   initial begin
      // a real falling edge so both clock domains take the asynchronous reset
      #1 i_rst_b = 1'b0;
      repeat (3) @(posedge i_clock);
      #1;
      cmp_byte({buf_en, arb_out, tr, d_oe, f_oe, k_oe, c_oe, a_oe}, 8'h3F);
      i_rst_b = 1'b1;
      foreach (rows[i]) begin
         {rx, coll, txc, ack} = rows[i][14:5];
         repeat (8) @(posedge i_clock);
         #1;
         cmp_bit(buf_en, rows[i][4]);
         cmp_byte({4'h0, d_oe, f_oe, k_oe, c_oe}, {4'h0, {4{~rows[i][4]}}});
         cmp_bit(f_o, rows[i][4]);
         cmp_bit(arb_out, rows[i][3]);
         cmp_bit(a_oe, ~rows[i][2]);
         cmp_bit(bus_act, rows[i][2]);
         cmp_bit(m_oe, ~rows[i][1]);
         cmp_bit(multi, rows[i][1]);
         cmp_bit(c_o, rows[i][0]);
         cmp_bit(a_o | m_o, 1'b0);
      end
      // fill the buffer while listening; the seventeenth byte is refused
      {rx, coll, txc, ack} = 10'h001;
      for (int k = 0; k < 17; k++) begin
         td = 8'(k * 29 + 3);
         tv = 1'b1;
         #1 cmp_bit(tr, 1'(k < 16));
         if (k < 16) sent.push_back(td);
         @(posedge i_clock);
         #1;
      end
      tv = 1'b0;
      // become source and read the wire like a listener, skipping the rise before bit 0
      rx = 4'h1;
      @(negedge w_k);
      for (int n = 0; n < 136; n++) begin
         @(posedge w_k);
         cmp_bit(w_d, n < 128 ? sent[n / 8][n % 8] : 1'b0);
         cmp_bit(w_f, 1'b1);
      end
      // reset in mid-frame releases every line at once
      @(posedge i_clock);
      #1 i_rst_b = 1'b0;
      #1 cmp_byte({3'h0, buf_en, d_oe, f_oe, k_oe, c_oe}, 8'h0F);
      repeat (3) @(posedge i_clock);
      #1 i_rst_b = 1'b1;
      rx = 4'h0;
      repeat (10) @(posedge i_clock);
      got.delete();
      ends = 0;
      #1;
      // peer sends three bytes and a stray nibble with a collision
      fork
         u_peer.send(28, 64'h9F03CA5, 1'b1);
         begin
            repeat (30) @(posedge i_clock);
            #1;
            cmp_bit(rc, 1'b1);
            cmp_bit(bus_act, 1'b1);
            cmp_bit(multi, 1'b1);
            cmp_bit(d_oe & buf_en === 1'b0, 1'b1);
         end
      join
      repeat (10) @(posedge i_clock);
      cmp_byte(8'(got.size()), 8'h03);
      for (int i = 0; i < 3 && i < got.size(); i++)
         cmp_byte(got[i], 8'(64'h9F03CA5 >> (8 * i)));
      cmp_byte(8'(ends), 8'h01);
      final_report();
   end
endmodule
`default_nettype wire
